// ### dac_cfg_pkg.sv
// shared constants and types of the converter configuration port
package dac_cfg_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [4:0] ADDR_DATA_PATH = 5'h02;
	localparam logic [4:0] ADDR_CAL_STATUS = 5'h0E;
	localparam logic [4:0] ADDR_CAL_CTRL = 5'h0F;
	localparam logic [4:0] ADDR_MEM_ADDR = 5'h10;
	localparam logic [4:0] ADDR_MEM_VALUE = 5'h11;
	localparam logic [4:0] ADDR_QUADRANT = 5'h15;
	localparam logic [4:0] ADDR_BYPASS = 5'h16;
	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_RATE = 6;
	localparam int BIT_IN_INV = 5;
	localparam int BIT_OUT_INV = 4;
	localparam int BIT_OUT_DIS = 3;
	localparam int BIT_MANUAL = 2;
	localparam int BIT_FORCE = 1;
	localparam int BIT_SELF_DONE = 7;
	localparam int BIT_SELF_START = 6;
	localparam int BIT_COPY_DONE = 5;
	localparam int BIT_COPY_START = 4;
	localparam int BIT_WMEM_WR = 3;
	localparam int BIT_WMEM_RD = 2;
	localparam int BIT_FACTORY_CAL_MEMORY_RD = 1;
	localparam int BIT_UNCALIBRATED_SELECT = 0;
	localparam int BIT_BYPASS = 6;
	localparam int BIT_EXT_QUAD = 5;
	// ****************************************
	// write masks and reset values
	// ****************************************
	localparam logic [7:0] MASK_DATA_PATH = 8'h7C;
	localparam logic [7:0] MASK_CAL_CTRL = 8'h5F;
	localparam logic [7:0] MASK_BYPASS = 8'h78;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [5:0] CAL_DEFAULT = 6'h3F;
	localparam logic [1:0] CAL_UNCALIBRATED_SELECT = 2'b00;
	localparam logic [1:0] CAL_SELF = 2'b01;
	localparam logic [1:0] CAL_FACTORY = 2'b10;
	localparam logic [1:0] CAL_USER = 2'b11;
	// ****************************************
	// timing counts
	// ****************************************
	localparam logic [8:0] SELFCAL_TICKS = 9'h100;
	localparam int PIPE_BYPASS = 4;
	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic dataRateSelect;
		logic inDclkInvert;
		logic outDclkInvert;
		logic outDclkDisable;
	} dp_ctrl_t;
	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_INSTR = 2'b01,
		SPI_DATA = 2'b10,
		SPI_DONE = 2'b11
	} spi_state_t;
	typedef enum logic [2:0] {
		OP_IDLE = 3'b000,
		OP_SELF = 3'b001,
		OP_COPY_RD = 3'b010,
		OP_COPY_WR = 3'b011,
		OP_FILL = 3'b100
	} cal_op_t;
endpackage : dac_cfg_pkg

// ### cal_memory.sv
// working and factory calibration memories with registered read data
`timescale 1ns/1ps
module cal_memory
	import dac_cfg_pkg::*;
#(
	parameter int AW = 8,
	parameter int DW = 6,
	parameter logic [5:0] FACTORY_VALUE = 6'h20
) (
	input wire logic clock,
	input wire logic [AW-1:0] addr,
	input wire logic writeEn,
	input wire logic [DW-1:0] writeData,
	input wire logic readFactory,
	output logic [DW-1:0] readData
);
	// ****************************************
	// storage
	// ****************************************
	logic [DW-1:0] working [2**AW];

	always_ff @(posedge clock) begin
		if (writeEn) begin
			working[addr] <= writeData;
		end
	end

	// factory contents are a constant table
	always_ff @(posedge clock) begin
		readData <= readFactory ? DW'(FACTORY_VALUE) : working[addr];
	end
endmodule : cal_memory

// ### cal_clock_divider.sv
// self-calibration clock divider, one tick per divided period
`timescale 1ns/1ps
module cal_clock_divider
	import dac_cfg_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	input wire logic [2:0] ratioCode,
	output logic tick
);
	logic [11:0] count;
	logic [11:0] limit;

	// code 0 gives 4096, each step halves down to 32
	assign limit = 12'((13'h1000 >> ratioCode) - 13'h0001);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= 12'h000;
			tick <= 1'b0;
		end else if (!run) begin
			count <= 12'h000;
			tick <= 1'b0;
		end else begin
			tick <= (count == limit);
			count <= (count == limit) ? 12'h000 : 12'(count + 12'h001);
		end
	end
endmodule : cal_clock_divider

// ### dac_serial_config_port.sv
// serial configuration port and control register bank
//
// Function
// - data-path bit 6 picks DDR (0) or SDR (1) capture
// - bits 5 and 4 invert input and output data clock
// - bit 3 turns the data clock output off
// - bit 2 selects manual sync, no automatic update
// - writing 1 to bit 1 forces a sync update
// - bit 0 reads 1 while sync logic needs update
// - calibration_status_clock bits 5:4 report calibration memory state
// - calibration_status_clock bits 2:0 pick self-cal clock divide 4096 down to 32
// - calibration_control bit 6 starts self-cal, bit 7 flags completion
// - calibration_control bit 4 starts factory copy, bit 5 flags completion
// - calibration_control bits 3,2,1 enable working write, working read, factory read
// - 0x10 holds memory address, 0x11 six-bit memory value
// - calibration_control bit 0 refills working memory with default 63
// - 0x15 bits 1:0 report the current sync quadrant
// - sync_bypass_control bit 6 bypasses the data synchronizer
// - sync_bypass_control bit 5 takes quadrant from bits 4:3
// - bypass path latency is four sample clocks
// - instruction byte on first eight rising edges, then data
// - chip select low restarts, high aborts the transfer
// - instruction holds read flag, byte count and address
// - instruction bit 7 high reads, low writes
// - count codes 0..3 move one to four bytes
// - MSB first decrements address, LSB first increments
// - read bits leave on falling edges after eighth rising edge
`timescale 1ns/1ps
module dac_serial_config_port
	import dac_cfg_pkg::*;
#(
	parameter int WORD_W = 16
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic chipSelectN,
	input wire logic serialClock,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOutEn,
	input wire logic lsbFirst,
	input wire logic syncDrift,
	input wire logic [1:0] autoQuadrant,
	output logic syncUpdate,
	output dp_ctrl_t dpCtrl,
	output logic dataClockOut,
	input wire logic [WORD_W-1:0] inputWord,
	output logic [WORD_W-1:0] outputWord
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// ****************************************
	// pin synchronisers and edges
	// ****************************************
	logic csMeta, csSync, sclkMeta, sclkSync, sclkPrev, sdiMeta, sdiSync;
	logic csActive, sclkRise, sclkFall;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			csMeta <= 1'b1;
			csSync <= 1'b1;
			sclkMeta <= 1'b0;
			sclkSync <= 1'b0;
			sclkPrev <= 1'b0;
			sdiMeta <= 1'b0;
			sdiSync <= 1'b0;
		end else begin
			csMeta <= chipSelectN;
			csSync <= csMeta;
			sclkMeta <= serialClock;
			sclkSync <= sclkMeta;
			sclkPrev <= sclkSync;
			sdiMeta <= serialDataIn;
			sdiSync <= sdiMeta;
		end
	end

	assign csActive = !csSync;
	assign sclkRise = csActive && sclkSync && !sclkPrev;
	assign sclkFall = csActive && !sclkSync && sclkPrev;

	// ****************************************
	// serial engine
	// ****************************************
	spi_state_t state;
	logic [2:0] bitCnt;
	logic [7:0] shiftReg, shiftNext, txShift, readByte;
	logic [4:0] curAddr, stepAddr, readAddr;
	logic [1:0] bytesLeft;
	logic isRead, byteDone, regWr;

	assign shiftNext = lsbFirst ? {sdiSync, shiftReg[7:1]} : {shiftReg[6:0], sdiSync};
	assign byteDone = sclkRise && (bitCnt == 3'h7);
	assign stepAddr = lsbFirst ? 5'(curAddr + 5'h01) : 5'(curAddr - 5'h01);
	assign regWr = (state == SPI_DATA) && byteDone && !isRead;
	assign readAddr = (state == SPI_INSTR) ? shiftNext[4:0] : stepAddr;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= SPI_IDLE;
			bitCnt <= 3'h0;
			shiftReg <= 8'h00;
			curAddr <= 5'h00;
			bytesLeft <= 2'b00;
			isRead <= 1'b0;
		end else if (!csActive) begin
			state <= SPI_IDLE;
			bitCnt <= 3'h0;
		end else begin
			if (sclkRise) begin
				shiftReg <= shiftNext;
				bitCnt <= 3'(bitCnt + 3'h1);
			end
			case (state)
				SPI_IDLE: begin
					state <= SPI_INSTR;
					bitCnt <= 3'h0;
				end
				SPI_INSTR: begin
					if (byteDone) begin
						isRead <= shiftNext[7];
						bytesLeft <= shiftNext[6:5];
						curAddr <= shiftNext[4:0];
						state <= SPI_DATA;
					end
				end
				SPI_DATA: begin
					if (byteDone) begin
						curAddr <= stepAddr;
						bytesLeft <= 2'(bytesLeft - 2'b01);
						if (bytesLeft == 2'b00) begin
							state <= SPI_DONE;
						end
					end
				end
				SPI_DONE: begin
					state <= SPI_DONE;
				end
				default: begin
					state <= SPI_IDLE;
				end
			endcase
		end
	end

	// read data leaves on falling edges
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			txShift <= 8'h00;
			serialDataOut <= 1'b0;
			serialDataOutEn <= 1'b0;
		end else if (!csActive) begin
			serialDataOutEn <= 1'b0;
			serialDataOut <= 1'b0;
		end else if (byteDone && (state == SPI_INSTR ? shiftNext[7] : isRead)) begin
			txShift <= readByte;
		end else if (sclkFall && state == SPI_DATA && isRead) begin
			serialDataOut <= lsbFirst ? txShift[0] : txShift[7];
			serialDataOutEn <= 1'b1;
			txShift <= lsbFirst ? {1'b0, txShift[7:1]} : {txShift[6:0], 1'b0};
		end
	end

	// ****************************************
	// register bank
	// ****************************************
	logic [7:0] dataPath, calCtrl, memAddr, bypassCtl;
	logic [2:0] calDiv;
	logic [1:0] calState, quadrant;
	logic [5:0] memValue, memRead;
	logic needFlag, calIdle, selfStart, copyStart, uncalStart;
	logic selfDone, copyDone, fillDone, userWrite, readPend, readCapture;
	cal_op_t calOp;

	assign calIdle = (calOp == OP_IDLE);
	assign selfStart = regWr && curAddr == ADDR_CAL_CTRL && shiftNext[BIT_SELF_START] && calIdle;
	assign copyStart = regWr && curAddr == ADDR_CAL_CTRL && shiftNext[BIT_COPY_START] && calIdle;
	assign uncalStart = regWr && curAddr == ADDR_CAL_CTRL && shiftNext[BIT_UNCALIBRATED_SELECT] && calIdle;

	always_comb begin
		case (readAddr)
			ADDR_DATA_PATH: readByte = dataPath | {7'h00, needFlag};
			ADDR_CAL_STATUS: readByte = {2'b00, calState, 1'b0, calDiv};
			ADDR_CAL_CTRL: readByte = calCtrl;
			ADDR_MEM_ADDR: readByte = memAddr;
			ADDR_MEM_VALUE: readByte = {2'b00, memValue};
			ADDR_QUADRANT: readByte = {6'h00, quadrant};
			ADDR_BYPASS: readByte = bypassCtl;
			default: readByte = 8'h00;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dataPath <= RST_REG;
			calDiv <= 3'b000;
			calCtrl <= RST_REG;
			memAddr <= RST_REG;
			memValue <= 6'h00;
			bypassCtl <= RST_REG;
		end else begin
			if (regWr) begin
				case (curAddr)
					ADDR_DATA_PATH: dataPath <= shiftNext & MASK_DATA_PATH;
					ADDR_CAL_STATUS: calDiv <= shiftNext[2:0];
					ADDR_CAL_CTRL: begin
						calCtrl <= (shiftNext & MASK_CAL_CTRL) | (calCtrl & ~MASK_CAL_CTRL);
						if (selfStart) begin
							calCtrl[BIT_SELF_DONE] <= 1'b0;
						end
						if (copyStart) begin
							calCtrl[BIT_COPY_DONE] <= 1'b0;
						end
					end
					ADDR_MEM_ADDR: memAddr <= shiftNext;
					ADDR_MEM_VALUE: memValue <= shiftNext[5:0];
					ADDR_BYPASS: bypassCtl <= shiftNext & MASK_BYPASS;
					default: memAddr <= memAddr;
				endcase
			end
			if (readCapture) begin
				memValue <= memRead;
			end
			// completion set wins over any clear in the same cycle
			if (selfDone) begin
				calCtrl[BIT_SELF_DONE] <= 1'b1;
				calCtrl[BIT_SELF_START] <= 1'b0;
			end
			if (copyDone) begin
				calCtrl[BIT_COPY_DONE] <= 1'b1;
				calCtrl[BIT_COPY_START] <= 1'b0;
			end
		end
	end

	assign dpCtrl.dataRateSelect = dataPath[BIT_RATE];
	assign dpCtrl.inDclkInvert = dataPath[BIT_IN_INV];
	assign dpCtrl.outDclkInvert = dataPath[BIT_OUT_INV];
	assign dpCtrl.outDclkDisable = dataPath[BIT_OUT_DIS];

	// ****************************************
	// data clock output
	// ****************************************
	logic dclkToggle;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dclkToggle <= 1'b0;
			dataClockOut <= 1'b0;
		end else begin
			dclkToggle <= !dclkToggle;
			dataClockOut <= dataPath[BIT_OUT_DIS] ? 1'b0 : (dclkToggle ^ dataPath[BIT_OUT_INV]);
		end
	end

	// ****************************************
	// sync logic control
	// ****************************************
	logic forceUpdate;

	assign forceUpdate = regWr && curAddr == ADDR_DATA_PATH && shiftNext[BIT_FORCE];
	assign syncUpdate = forceUpdate || (!dataPath[BIT_MANUAL] && needFlag);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			needFlag <= 1'b0;
			quadrant <= 2'b00;
		end else begin
			needFlag <= syncDrift || (needFlag && !syncUpdate);
			if (bypassCtl[BIT_EXT_QUAD]) begin
				quadrant <= bypassCtl[4:3];
			end else if (syncUpdate) begin
				quadrant <= autoQuadrant;
			end
		end
	end

	// ****************************************
	// data path
	// ****************************************
	logic [WORD_W-1:0] pipe [PIPE_BYPASS];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < PIPE_BYPASS; i++) begin
				pipe[i] <= '0;
			end
			outputWord <= '0;
		end else begin
			pipe[0] <= inputWord;
			for (int i = 1; i < PIPE_BYPASS; i++) begin
				pipe[i] <= pipe[i-1];
			end
			outputWord <= bypassCtl[BIT_BYPASS] ? pipe[PIPE_BYPASS-2] : pipe[PIPE_BYPASS-1];
		end
	end

	// ****************************************
	// calibration sequencer and memory
	// ****************************************
	logic [7:0] calIdx, memPortAddr;
	logic [8:0] tickCnt;
	logic calTick, memWe, memFactory;
	logic [5:0] memWd;

	assign selfDone = (calOp == OP_SELF) && calTick && tickCnt == 9'(SELFCAL_TICKS - 9'h001);
	assign copyDone = (calOp == OP_COPY_WR) && calIdx == 8'hFF;
	assign fillDone = (calOp == OP_FILL) && calIdx == 8'hFF;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			calOp <= OP_FILL;
			calIdx <= 8'h00;
			tickCnt <= 9'h000;
		end else begin
			case (calOp)
				OP_IDLE: begin
					calIdx <= 8'h00;
					tickCnt <= 9'h000;
					if (uncalStart) begin
						calOp <= OP_FILL;
					end else if (copyStart) begin
						calOp <= OP_COPY_RD;
					end else if (selfStart) begin
						calOp <= OP_SELF;
					end
				end
				OP_SELF: begin
					if (calTick) begin
						tickCnt <= 9'(tickCnt + 9'h001);
					end
					if (selfDone) begin
						calOp <= OP_IDLE;
					end
				end
				OP_COPY_RD: calOp <= OP_COPY_WR;
				OP_COPY_WR: begin
					calIdx <= 8'(calIdx + 8'h01);
					calOp <= copyDone ? OP_IDLE : OP_COPY_RD;
				end
				OP_FILL: begin
					calIdx <= 8'(calIdx + 8'h01);
					if (fillDone) begin
						calOp <= OP_IDLE;
					end
				end
				default: calOp <= OP_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			calState <= CAL_UNCALIBRATED_SELECT;
			userWrite <= 1'b0;
			readPend <= 1'b0;
			readCapture <= 1'b0;
		end else begin
			userWrite <= regWr && curAddr == ADDR_MEM_VALUE && calCtrl[BIT_WMEM_WR];
			readPend <= regWr && curAddr == ADDR_MEM_ADDR
				&& (calCtrl[BIT_WMEM_RD] || calCtrl[BIT_FACTORY_CAL_MEMORY_RD]);
			readCapture <= readPend;
			if (fillDone) begin
				calState <= CAL_UNCALIBRATED_SELECT;
			end else if (selfDone) begin
				calState <= CAL_SELF;
			end else if (copyDone) begin
				calState <= CAL_FACTORY;
			end else if (userWrite) begin
				calState <= CAL_USER;
			end
		end
	end

	always_comb begin
		memPortAddr = memAddr;
		memWe = userWrite && calIdle;
		memWd = memValue;
		memFactory = calCtrl[BIT_FACTORY_CAL_MEMORY_RD];
		case (calOp)
			OP_FILL: begin
				memPortAddr = calIdx;
				memWe = 1'b1;
				memWd = CAL_DEFAULT;
			end
			OP_COPY_RD: begin
				memPortAddr = calIdx;
				memFactory = 1'b1;
			end
			OP_COPY_WR: begin
				memPortAddr = calIdx;
				memWe = 1'b1;
				memWd = memRead;
			end
			default: memFactory = calCtrl[BIT_FACTORY_CAL_MEMORY_RD];
		endcase
	end

	cal_memory u_mem (
		.clock(clock),
		.addr(memPortAddr),
		.writeEn(memWe),
		.writeData(memWd),
		.readFactory(memFactory),
		.readData(memRead)
	);

	cal_clock_divider u_div (
		.clock(clock),
		.rst(rst),
		.run(calOp == OP_SELF),
		.ratioCode(calDiv),
		.tick(calTick)
	);

	// ****************************************
	// assertions
	// ****************************************
	property p_rate;
		regWr && curAddr == ADDR_DATA_PATH |=> dpCtrl.dataRateSelect == $past(shiftNext[BIT_RATE]);
	endproperty
	a_rate: assert property (p_rate) else $error("data rate bit not stored");

	property p_dclk_off;
		dataPath[BIT_OUT_DIS] && $past(dataPath[BIT_OUT_DIS]) |-> !dataClockOut;
	endproperty
	a_dclk_off: assert property (p_dclk_off) else $error("data clock driven while off");

	property p_manual;
		dataPath[BIT_MANUAL] && !forceUpdate |-> !syncUpdate;
	endproperty
	a_manual: assert property (p_manual) else $error("sync updated in manual mode");

	property p_need;
		syncDrift |=> needFlag && (readAddr != ADDR_DATA_PATH || readByte[0]);
	endproperty
	a_need: assert property (p_need) else $error("sync need flag missing");

	property p_self_done;
		selfDone |=> calCtrl[BIT_SELF_DONE] && !calCtrl[BIT_SELF_START] ##1 calState == CAL_SELF;
	endproperty
	a_self_done: assert property (p_self_done) else $error("self-cal completion wrong");

	property p_bypass;
		bypassCtl[BIT_BYPASS] [*5] |-> outputWord == $past(inputWord, 4);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass latency not four");

	property p_sdo;
		sclkFall && state == SPI_DATA && isRead |=> serialDataOutEn;
	endproperty
	a_sdo: assert property (p_sdo) else $error("read bit not driven");

	property p_abort;
		!csActive |=> state == SPI_IDLE ##1 !serialDataOutEn;
	endproperty
	a_abort: assert property (p_abort) else $error("transfer not aborted");

	property p_step;
		state == SPI_DATA && byteDone && !lsbFirst |=> curAddr == 5'($past(curAddr) - 5'h01);
	endproperty
	a_step: assert property (p_step) else $error("address not decremented");

	property p_uncalibrated_select;
		uncalStart |=> calOp == OP_FILL ##[1:300] calState == CAL_UNCALIBRATED_SELECT;
	endproperty
	a_uncalibrated_select: assert property (p_uncalibrated_select) else $error("default refill missing");
endmodule : dac_serial_config_port

// ### spi_host_model.sv
// serial host model that frames transfers to the configuration port
`timescale 1ns/1ps
module spi_host_model (
	input wire logic clock,
	input wire logic serialDataOut,
	input wire logic serialDataOutEn,
	input wire logic lsbFirst,
	output logic chipSelectN,
	output logic serialClock,
	output logic serialDataIn
);
	logic lastOut = 1'b0;
	logic sdoSeen;
	initial begin
		chipSelectN = 1'b1;
		serialClock = 1'b0;
		serialDataIn = 1'b0;
	end
	// ****************************************
	// released output line
	// ****************************************
	always @(posedge clock) begin
		if (serialDataOutEn) begin
			lastOut <= serialDataOut;
		end
	end
	// undriven line shows inverse of last level
	assign sdoSeen = serialDataOutEn ? serialDataOut : ~lastOut;
	// ****************************************
	// one frame, cut short below full length
	// ****************************************
	task automatic xfer(input logic [7:0] instr, input logic [31:0] wdata, input int nBits,
		output logic [31:0] rdata);
		logic [39:0] frame;
		int b;
		frame = {instr, wdata};
		rdata = '0;
		@(negedge clock);
		chipSelectN = 1'b0;
		repeat (4) @(negedge clock);
		for (int i = 0; i < nBits; i++) begin
			b = lsbFirst ? ((i / 8) * 8 + 7 - (i % 8)) : i;
			serialDataIn = frame[39-b];
			repeat (4) @(negedge clock);
			serialClock = 1'b1;
			if (i >= 8) begin
				rdata[39-b] = sdoSeen;
			end
			repeat (4) @(negedge clock);
			serialClock = 1'b0;
		end
		serialDataIn = ~serialDataIn;
		repeat (4) @(negedge clock);
		chipSelectN = 1'b1;
		repeat (6) @(negedge clock);
	endtask : xfer
endmodule : spi_host_model

// ### tb.sv
// self-checking bench of the configuration port
`timescale 1ns/1ps
module tb
	import dac_cfg_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic chipSelectN, serialClock, serialDataIn, serialDataOut, serialDataOutEn;
	logic lsbFirst = 1'b0;
	logic syncDrift = 1'b0;
	logic [1:0] autoQuadrant = 2'b10;
	logic syncUpdate, dataClockOut;
	dp_ctrl_t dpCtrl;
	logic [15:0] inputWord = 16'h0000;
	logic [15:0] outputWord;
	int error_cnt = 0;
	int cmp_count = 0;
	int updCount = 0;
	logic [31:0] r, rnd;
	logic [7:0] a, d, v, ma, mv;
	logic prevClk;
	localparam logic [4:0] ADDR_LIST [0:6] = '{ADDR_DATA_PATH, ADDR_CAL_STATUS, ADDR_CAL_CTRL,
		ADDR_MEM_ADDR, ADDR_MEM_VALUE, ADDR_QUADRANT, ADDR_BYPASS};
	always #20 clock = ~clock;
	always @(negedge clock) begin
		if (syncUpdate === 1'b1) begin
			updCount++;
		end
	end
	dac_serial_config_port dut (.clock(clock), .rst(rst), .chipSelectN(chipSelectN),
		.serialClock(serialClock), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
		.serialDataOutEn(serialDataOutEn), .lsbFirst(lsbFirst), .syncDrift(syncDrift),
		.autoQuadrant(autoQuadrant), .syncUpdate(syncUpdate), .dpCtrl(dpCtrl),
		.dataClockOut(dataClockOut), .inputWord(inputWord), .outputWord(outputWord));
	spi_host_model host (.clock(clock), .serialDataOut(serialDataOut),
		.serialDataOutEn(serialDataOutEn), .lsbFirst(lsbFirst), .chipSelectN(chipSelectN),
		.serialClock(serialClock), .serialDataIn(serialDataIn));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] exp_dp(input logic [7:0] w, input logic drift);
		return (w & MASK_DATA_PATH) | {7'h00, drift};
	endfunction : exp_dp
	task automatic close_out();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [4:0] ad, input logic [7:0] w);
		logic [31:0] q;
		host.xfer({3'b000, ad}, {w, 24'h000000}, 16, q);
	endtask : wr
	task automatic rdchk(input string name, input logic [4:0] ad, input logic [7:0] e);
		logic [31:0] q;
		host.xfer({3'b100, ad}, 32'h0000_0000, 16, q);
		chk(name, {24'h000000, e}, {24'h000000, q[31:24]});
	endtask : rdchk
	task automatic pipe(input int lat);
		logic [15:0] w [0:19];
		for (int k = 0; k < 20; k++) begin
			@(negedge clock);
			if (k >= lat) begin
				chk("outputWord", {16'h0000, w[k-lat]}, {16'h0000, outputWord});
			end
			w[k] = 16'($urandom);
			inputWord = w[k];
		end
	endtask : pipe
	task automatic clk_out(input logic off);
		for (int k = 0; k < 6; k++) begin
			@(negedge clock);
			prevClk = dataClockOut;
			@(negedge clock);
			chk("dataClockOut", off ? 32'h0 : {31'h0, ~prevClk}, {31'h0, dataClockOut});
		end
	endtask : clk_out
	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		close_out();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rnd = $urandom(32'he38a);
		repeat (8) @(negedge clock);
		rst = 1'b0;
		for (int i = 0; i < 7; i++) begin
			rdchk("reset", ADDR_LIST[i], 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wr(ADDR_DATA_PATH, v);
			rdchk("dataPath", ADDR_DATA_PATH, exp_dp(v, 1'b0));
			chk("dpCtrl", {28'h0, v[6:3]}, {28'h0, dpCtrl});
		end
		wr(ADDR_DATA_PATH, 8'h08);
		clk_out(1'b1);
		wr(ADDR_DATA_PATH, 8'h00);
		clk_out(1'b0);
		wr(ADDR_DATA_PATH, 8'h04);
		syncDrift = 1'b1;
		updCount = 0;
		rdchk("syncNeeded", ADDR_DATA_PATH, 8'h05);
		chk("noAutoUpdate", 32'h0, updCount);
		wr(ADDR_DATA_PATH, 8'h06);
		chk("forceUpdate", 32'h1, {31'h0, updCount > 0});
		syncDrift = 1'b0;
		wr(ADDR_DATA_PATH, 8'h00);
		rdchk("autoQuadrant", ADDR_QUADRANT, 8'h02);
		for (int q = 0; q < 4; q++) begin
			wr(ADDR_BYPASS, 8'h20 | 8'(q << 3));
			rdchk("quadrant", ADDR_QUADRANT, 8'(q));
			rdchk("bypassReg", ADDR_BYPASS, (8'h20 | 8'(q << 3)) & MASK_BYPASS);
		end
		wr(ADDR_QUADRANT, 8'hFF);
		rdchk("roQuadrant", ADDR_QUADRANT, 8'h03);
		wr(ADDR_CAL_STATUS, 8'hFF);
		rdchk("calStatus", ADDR_CAL_STATUS, 8'h07);
		wr(ADDR_BYPASS, 8'h40);
		pipe(PIPE_BYPASS);
		wr(ADDR_BYPASS, 8'h00);
		pipe(PIPE_BYPASS + 1);
		a = 8'($urandom);
		d = 8'($urandom);
		host.xfer({3'b001, ADDR_MEM_VALUE}, {d, a, 16'h0000}, 24, r);
		for (int n = 0; n < 4; n++) begin
			host.xfer({1'b1, 2'(n), ADDR_MEM_VALUE}, 32'h0, 16 + 8 * n, r);
			chk("multiRead", {d & 8'h3F, a, 16'h0007} & ~(32'hFFFF_FFFF >> (8 * n + 8)), r);
		end
		lsbFirst = 1'b1;
		host.xfer({3'b001, ADDR_MEM_ADDR}, {a ^ 8'hFF, d, 16'h0000}, 24, r);
		lsbFirst = 1'b0;
		rdchk("lsbFirst0", ADDR_MEM_ADDR, a ^ 8'hFF);
		rdchk("lsbFirst1", ADDR_MEM_VALUE, d & 8'h3F);
		host.xfer({3'b000, ADDR_MEM_ADDR}, {a, 24'h000000}, 12, r);
		rdchk("abort", ADDR_MEM_ADDR, a ^ 8'hFF);
		ma = 8'($urandom);
		mv = 8'($urandom) & 8'h3F;
		wr(ADDR_CAL_CTRL, 8'h08);
		wr(ADDR_MEM_ADDR, ma);
		wr(ADDR_MEM_VALUE, mv);
		rdchk("userState", ADDR_CAL_STATUS, 8'h37);
		wr(ADDR_CAL_CTRL, 8'h04);
		wr(ADDR_MEM_ADDR, ma);
		rdchk("memRead", ADDR_MEM_VALUE, mv);
		wr(ADDR_MEM_ADDR, ma + 8'h01);
		rdchk("memDefault", ADDR_MEM_VALUE, 8'h3F);
		wr(ADDR_CAL_CTRL, 8'h02);
		wr(ADDR_MEM_ADDR, ma);
		rdchk("factoryRead", ADDR_MEM_VALUE, 8'h20);
		wr(ADDR_CAL_CTRL, 8'h10);
		repeat (600) @(negedge clock);
		host.xfer({3'b100, ADDR_CAL_CTRL}, 32'h0, 16, r);
		chk("copyDone", 32'h2000_0000, r & 32'h2000_0000);
		rdchk("factoryState", ADDR_CAL_STATUS, 8'h27);
		wr(ADDR_CAL_CTRL, 8'h04);
		wr(ADDR_MEM_ADDR, ma);
		rdchk("copied", ADDR_MEM_VALUE, 8'h20);
		wr(ADDR_CAL_CTRL, 8'h01);
		repeat (300) @(negedge clock);
		rdchk("uncalState", ADDR_CAL_STATUS, 8'h07);
		wr(ADDR_CAL_CTRL, 8'h04);
		wr(ADDR_MEM_ADDR, ma);
		rdchk("refilled", ADDR_MEM_VALUE, 8'h3F);
		wr(ADDR_CAL_CTRL, 8'h40);
		repeat (8800) @(negedge clock);
		host.xfer({3'b100, ADDR_CAL_CTRL}, 32'h0, 16, r);
		chk("selfDone", 32'h8000_0000, r & 32'h8000_0000);
		rdchk("selfState", ADDR_CAL_STATUS, 8'h17);
		wr(ADDR_CAL_STATUS, 8'h06);
		wr(ADDR_CAL_CTRL, 8'h40);
		repeat (15000) @(negedge clock);
		host.xfer({3'b100, ADDR_CAL_CTRL}, 32'h0, 16, r);
		chk("selfEarly", 32'h0, r & 32'h8000_0000);
		repeat (2000) @(negedge clock);
		host.xfer({3'b100, ADDR_CAL_CTRL}, 32'h0, 16, r);
		chk("selfDiv64", 32'h8000_0000, r & 32'h8000_0000);
		close_out();
	end
endmodule : tb
